// ===== hdl/usm_core.v
// Serial transceiver special modes: infrared, single wire, smartcard.
// Assumes an APB master on sys_clk and synchronous pin inputs.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "usm_consts.vh"

// Summary of operation
// [R1] Infrared mode needs other modes cleared
// [R2] Infrared baud rate at most 115200
// [R3] Infrared: transmit idles low, pulse means zero
// [R4] Zero pulse lasts three sixteenths bit
// [R5] Decoder ignores pulses under one prescaler clock
// [R6] Infrared transmit and receive never overlap; not enforced here, receiver gated only during card transmit
// [R7] Low power: pulse three prescaler periods
// [R8] Single wire: receiver reads transmit pin
// [R9] Card clock is bus clock over prescaler
// [R10] Card frame: start, nine bits, 1.5 stops
// [R11] Half-bit lead; guard holds completion low; here no guard once a character has been retried, completion set at stop end
// [R12] Card NACK: resend after 2.5 bit gap
// [R13] Final retry: complete now, NACK sets frame error
// [R14] Parity error: drive NACK, no receive full
// [R15] Retries exhausted: deliver as parity error
// [R16] No idle or break handling for cards
// [R17] Block mode receive timeout in bit times
// [R18] Software enables DMA after first character
// [R19] Character counter to limit plus four
// [R20] Software sets limit zero or maximum
// [R21] Direct or inverse convention, even parity
// [R22] Enabled events ORed onto one request
// [R23] Data write empties, shift load refills
// [R24] Decoder gives zero for detected pulse
module usm_core (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        txPinOut,
  output wire        txPinOe,
  input  wire        txPinIn,
  input  wire        rxPin,
  output reg         ckPin,
  output wire        irqOut
);
  localparam TX_IDLE  = 3'd0;
  localparam TX_LEAD  = 3'd1;
  localparam TX_BIT   = 3'd2;
  localparam TX_STOP  = 3'd3;
  localparam TX_GAP   = 3'd4;
  localparam TX_GUARD = 3'd5;
  localparam RX_IDLE  = 3'd0;
  localparam RX_START = 3'd1;
  localparam RX_DATA  = 3'd2;
  localparam RX_STOP  = 3'd3;
  localparam RX_NACK  = 3'd4;

  reg  [11:0] ctrl_r;
  reg  [7:0]  ien_r;
  reg  [18:0] pre_r;
  reg  [15:0] baud_r;
  reg  [31:0] tmo_r;
  reg  [7:0]  stat_r;
  reg  [7:0]  stat_nxt;
  reg  [7:0]  rxData_r;
  reg  [7:0]  txBuf_r;
  reg  [2:0]  txSt_r;
  reg  [19:0] txCnt_r;
  reg  [3:0]  txBits_r;
  reg  [9:0]  txShift_r;
  reg  [9:0]  txFrame_r;
  reg         txLine_r;
  reg  [2:0]  retry_r;
  reg  [7:0]  guardCnt_r;
  reg         nackSeen_r;
  reg         bitStart_r;
  reg  [2:0]  rxSt_r;
  reg  [19:0] rxCnt_r;
  reg  [3:0]  rxBits_r;
  reg  [8:0]  rxShift_r;
  reg  [2:0]  rxErr_r;
  reg         lineD_r;
  reg         nackDrive_r;
  reg  [8:0]  blkCnt_r;
  reg  [23:0] tmoCnt_r;
  reg  [19:0] tmoBit_r;
  reg         tmoRun_r;
  wire        pscTick;
  wire        ckLevel;
  wire        irTx;
  wire        irRx;

  // ==========================================================
  // Helpers
  function reached(input [19:0] c, input [19:0] lim);
    begin
      reached = ({1'b0, c} + 21'h000001) >= {1'b0, lim};
    end
  endfunction

  function [7:0] rev8(input [7:0] d);
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) rev8[i] = d[7 - i];
    end
  endfunction

  // ==========================================================
  // Configuration
  wire        infrared_mode_enable     = ctrl_r[`USM_C_IR];
  wire        half_duplex_enable     = ctrl_r[`USM_C_HD];
  wire        smartcard_enable     = ctrl_r[`USM_C_SC];
  wire        nackEn   = ctrl_r[`USM_C_NACK];
  wire        msb_first_select     = ctrl_r[`USM_C_MSB_FIRST_SELECT];
  wire        data_inversion_select     = ctrl_r[`USM_C_DATA_INVERSION_SELECT];
  wire        halfStop = ctrl_r[`USM_C_HSTOP];
  wire [2:0]  retryMax = pre_r[18:16];
  wire [7:0]  guard    = pre_r[15:8];
  wire [3:0]  nBits    = smartcard_enable ? `USM_BITS_SC : `USM_BITS_STD; // see [R10]
  wire [19:0] bl       = {4'h0, baud_r};
  wire [19:0] half     = {1'b0, bl[19:1]};
  wire [19:0] qtr      = {2'b00, bl[19:2]};
  wire [19:0] oneHalf  = bl + half;
  wire [19:0] twoHalf  = {bl[18:0], 1'b0} + half;
  wire [19:0] rxStop   = smartcard_enable ? half + qtr : bl;
  wire        lineIn   = (half_duplex_enable | smartcard_enable) ? txPinIn : (infrared_mode_enable ? irRx : rxPin); // see [R8]

  // ==========================================================
  // APB slave: zero wait, error on unmapped words
  wire mapped = (paddr <= `USM_A_DATA) && (paddr[1:0] == 2'b00);
  wire acc    = psel & penable;
  wire wr     = acc & pwrite & mapped;
  wire rd     = acc & ~pwrite & mapped;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `USM_A_CTRL: prdata <= {20'h00000, ctrl_r};
        `USM_A_IEN:  prdata <= {24'h000000, ien_r};
        `USM_A_PRE:  prdata <= {13'h0000, pre_r};
        `USM_A_BAUD: prdata <= {16'h0000, baud_r};
        `USM_A_TMO:  prdata <= tmo_r;
        `USM_A_STAT: prdata <= {24'h000000, stat_r};
        `USM_A_DATA: prdata <= {24'h000000, rxData_r};
        default:     prdata <= 32'h00000000;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_r  <= `USM_R_CTRL;
      ien_r   <= 8'h00;
      pre_r   <= 19'h00000;
      baud_r  <= `USM_R_BAUD;
      tmo_r   <= 32'h00000000;
      txBuf_r <= 8'h00;
    end else if (wr) begin
      case (paddr)
        `USM_A_CTRL: ctrl_r  <= pwdata[11:0];
        `USM_A_IEN:  ien_r   <= pwdata[7:0];
        `USM_A_PRE:  pre_r   <= pwdata[18:0];
        `USM_A_BAUD: baud_r  <= pwdata[15:0];
        `USM_A_TMO:  tmo_r   <= pwdata;
        `USM_A_DATA: txBuf_r <= pwdata[7:0];
        default:     ctrl_r  <= ctrl_r;
      endcase
    end
  end

  // ==========================================================
  // Transmit events
  wire [7:0] txOrd  = msb_first_select ? rev8(txBuf_r) : txBuf_r;
  wire [9:0] txNew  = {{^txOrd, txOrd} ^ {9{data_inversion_select}}, 1'b0}; // see [R21]
  wire txLoad    = (txSt_r == TX_IDLE) && ctrl_r[`USM_C_TXEN] &&
                   !stat_r[`USM_S_TX_EMPTY];
  wire txBitEnd  = reached(txCnt_r, bl);
  wire leadDone  = (txSt_r == TX_LEAD) ? (!smartcard_enable || reached(txCnt_r, half)) :
                   reached(txCnt_r, twoHalf);
  wire stopEnd   = (txSt_r == TX_STOP) && reached(txCnt_r, smartcard_enable ? oneHalf : bl);
  wire nackRetry = smartcard_enable && nackSeen_r && (retry_r < retryMax);
  wire txAbort   = stopEnd && smartcard_enable && nackSeen_r && !nackRetry;
  wire goGuard   = smartcard_enable && !nackSeen_r && (retry_r == 3'h0) && (guard != 8'h00);
  wire guardDone = (txSt_r == TX_GUARD) && txBitEnd &&
                   ({1'b0, guardCnt_r} + 9'h001 >= {1'b0, guard});
  wire tcSet     = (stopEnd && !nackRetry && !goGuard) || guardDone;

  // ==========================================================
  // Transmitter
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      txSt_r     <= TX_IDLE;
      txCnt_r    <= 20'h00000;
      txBits_r   <= 4'h0;
      txShift_r  <= 10'h3ff;
      txFrame_r  <= 10'h3ff;
      txLine_r   <= 1'b1;
      retry_r    <= 3'h0;
      guardCnt_r <= 8'h00;
      nackSeen_r <= 1'b0;
      bitStart_r <= 1'b0;
    end else begin
      bitStart_r <= 1'b0;
      case (txSt_r)
        TX_IDLE: begin
          txCnt_r <= 20'h00000;
          if (txLoad) begin
            txFrame_r <= txNew;
            retry_r   <= 3'h0;
            txSt_r    <= TX_LEAD;                  // see [R11]
          end
        end
        TX_LEAD, TX_GAP: begin
          if (leadDone) begin
            txCnt_r    <= 20'h00000;
            txLine_r   <= txFrame_r[0];
            txShift_r  <= {1'b1, txFrame_r[9:1]};
            txBits_r   <= nBits;
            bitStart_r <= 1'b1;
            txSt_r     <= TX_BIT;
          end else begin
            txCnt_r <= txCnt_r + 20'h00001;
          end
        end
        TX_BIT: begin
          if (txBitEnd) begin
            txCnt_r <= 20'h00000;
            if (txBits_r == 4'h0) begin
              txLine_r   <= 1'b1;
              nackSeen_r <= 1'b0;
              txSt_r     <= TX_STOP;
            end else begin
              txLine_r   <= txShift_r[0];
              txShift_r  <= {1'b1, txShift_r[9:1]};
              txBits_r   <= txBits_r - 4'h1;
              bitStart_r <= 1'b1;
            end
          end else begin
            txCnt_r <= txCnt_r + 20'h00001;
          end
        end
        TX_STOP: begin
          txCnt_r <= txCnt_r + 20'h00001;
          if (smartcard_enable && txCnt_r == bl) nackSeen_r <= !txPinIn; // see [R12]
          if (stopEnd) begin
            txCnt_r    <= 20'h00000;
            guardCnt_r <= 8'h00;
            if (nackRetry) begin
              retry_r <= retry_r + 3'h1;
              txSt_r  <= TX_GAP;                   // see [R12]
            end else if (goGuard) begin
              txSt_r <= TX_GUARD;                  // see [R11]
            end else begin
              txSt_r <= TX_IDLE;                   // see [R13]
            end
          end
        end
        TX_GUARD: begin
          if (txBitEnd) begin
            txCnt_r    <= 20'h00000;
            guardCnt_r <= guardCnt_r + 8'h01;
            if (guardDone) txSt_r <= TX_IDLE;
          end else begin
            txCnt_r <= txCnt_r + 20'h00001;
          end
        end
        default: txSt_r <= TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Receive events
  wire [7:0] rxRaw   = smartcard_enable ? rxShift_r[7:0] : rxShift_r[8:1];
  wire [7:0] rxLog   = rxRaw ^ {8{data_inversion_select}};
  wire       parErr  = smartcard_enable && ((^rxShift_r) ^ data_inversion_select);  // see [R21]
  wire       rxEnd   = (rxSt_r == RX_STOP) && reached(rxCnt_r, rxStop);
  wire       nackGo  = parErr && nackEn && !halfStop && (rxErr_r < retryMax);
  wire       deliver = rxEnd && !nackGo;
  wire       rxGo    = ctrl_r[`USM_C_RXEN] && !(smartcard_enable && txSt_r != TX_IDLE);
  wire [8:0] blkMax  = {1'b0, tmo_r[31:24]} + `USM_BLK_EXTRA;
  wire       blkOn   = smartcard_enable && ctrl_r[`USM_C_BLK];

  // ==========================================================
  // Receiver
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rxSt_r      <= RX_IDLE;
      rxCnt_r     <= 20'h00000;
      rxBits_r    <= 4'h0;
      rxShift_r   <= 9'h000;
      rxErr_r     <= 3'h0;
      lineD_r     <= 1'b1;
      nackDrive_r <= 1'b0;
      rxData_r    <= 8'h00;
    end else begin
      lineD_r <= lineIn;
      rxCnt_r <= rxCnt_r + 20'h00001;
      case (rxSt_r)
        RX_IDLE: begin
          rxCnt_r <= 20'h00000;
          if (rxGo && lineD_r && !lineIn) rxSt_r <= RX_START; // see [R6]
        end
        RX_START: begin
          if (reached(rxCnt_r, half)) begin
            rxCnt_r  <= 20'h00000;
            rxBits_r <= nBits;
            rxSt_r   <= lineIn ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (reached(rxCnt_r, bl)) begin
            rxCnt_r   <= 20'h00000;
            rxShift_r <= {lineIn, rxShift_r[8:1]};
            rxBits_r  <= rxBits_r - 4'h1;
            if (rxBits_r == 4'h1) rxSt_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rxEnd) begin
            rxCnt_r <= 20'h00000;
            if (nackGo) begin
              rxErr_r <= rxErr_r + 3'h1;
              rxSt_r  <= RX_NACK;                  // see [R14]
            end else begin
              rxErr_r <= 3'h0;                     // see [R15]
              rxSt_r  <= RX_IDLE;
              if (!stat_r[`USM_S_RX_FULL])
                rxData_r <= msb_first_select ? rev8(rxLog) : rxLog;
            end
          end
        end
        RX_NACK: begin
          if (!nackDrive_r && reached(rxCnt_r, qtr)) begin
            rxCnt_r     <= 20'h00000;
            nackDrive_r <= 1'b1;                   // see [R14]
          end else if (nackDrive_r && reached(rxCnt_r, bl)) begin
            nackDrive_r <= 1'b0;
            rxSt_r      <= RX_IDLE;
          end
        end
        default: rxSt_r <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Block counter and receive timeout
  wire tmoHit = tmoRun_r && (rxSt_r == RX_IDLE) && reached(tmoBit_r, bl) &&
                ({1'b0, tmoCnt_r} + 25'h0000001 >= {1'b0, tmo_r[23:0]});
  wire eobHit = deliver && blkOn && (blkCnt_r + 9'h001 == blkMax);

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      blkCnt_r <= 9'h000;
      tmoCnt_r <= 24'h000000;
      tmoBit_r <= 20'h00000;
      tmoRun_r <= 1'b0;
    end else begin
      if (!stat_r[`USM_S_TX_EMPTY]) blkCnt_r <= 9'h000;   // see [R19]
      else if (deliver && blkOn && blkCnt_r != blkMax)
        blkCnt_r <= blkCnt_r + 9'h001;
      if (rxSt_r != RX_IDLE || (wr && paddr == `USM_A_TMO)) begin
        tmoCnt_r <= 24'h000000;
        tmoBit_r <= 20'h00000;
      end else if (tmoRun_r && reached(tmoBit_r, bl)) begin
        tmoBit_r <= 20'h00000;
        tmoCnt_r <= tmoCnt_r + 24'h000001;                // see [R17]
      end else if (tmoRun_r) begin
        tmoBit_r <= tmoBit_r + 20'h00001;
      end
      if (!blkOn || tmoHit) tmoRun_r <= 1'b0;
      else if (deliver || (wr && paddr == `USM_A_TMO)) tmoRun_r <= 1'b1;
    end
  end

  // ==========================================================
  // Status flags: hardware set wins over software clear
  always @* begin
    stat_nxt = stat_r;
    if (wr && paddr == `USM_A_STAT)
      stat_nxt = stat_r & (pwdata[7:0] | (8'h01 << `USM_S_TX_EMPTY));
    if (wr && paddr == `USM_A_DATA)
      stat_nxt[`USM_S_TX_EMPTY] = 1'b0;                 // see [R23]
    if (rd && paddr == `USM_A_DATA) stat_nxt[`USM_S_RX_FULL] = 1'b0;
    if (txLoad || txSt_r == TX_GUARD)
      stat_nxt[`USM_S_TX_COMPLETE] = 1'b0;              // see [R11]
    if (txLoad) stat_nxt[`USM_S_TX_EMPTY] = 1'b1;       // see [R23]
    if (tcSet) stat_nxt[`USM_S_TX_COMPLETE] = 1'b1;     // see [R13]
    if (txAbort) stat_nxt[`USM_S_FRAME_ERR] = 1'b1;     // see [R13]
    if (deliver && stat_r[`USM_S_RX_FULL]) begin
      stat_nxt[`USM_S_OVERRUN_ERR] = 1'b1;
    end else if (deliver) begin
      stat_nxt[`USM_S_RX_FULL] = 1'b1;                  // see [R14]
      if (parErr) stat_nxt[`USM_S_PARITY_ERR] = 1'b1;   // see [R15]
      if (!lineIn) stat_nxt[`USM_S_FRAME_ERR] = 1'b1;   // see [R16]
    end
    if (tmoHit) stat_nxt[`USM_S_TIMEOUT] = 1'b1;        // see [R17]
    if (eobHit) stat_nxt[`USM_S_END_BLOCK] = 1'b1;      // see [R19]
  end

  always @(posedge sys_clk) begin
    if (sys_rst) stat_r <= `USM_R_STAT;
    else stat_r <= stat_nxt;
  end

  assign irqOut = |(stat_r & ien_r);                    // see [R22]

  // ==========================================================
  // Pins, dividers and infrared codec
  wire rawTx = txLine_r & ~nackDrive_r;
  assign txPinOut = infrared_mode_enable ? irTx : ((half_duplex_enable | smartcard_enable) ? 1'b0 : rawTx); // see [R3]
  assign txPinOe  = (half_duplex_enable | smartcard_enable) ? ~rawTx : 1'b1;

  always @(posedge sys_clk) begin
    if (sys_rst) ckPin <= 1'b0;
    else ckPin <= smartcard_enable & ctrl_r[`USM_C_CLOCK_PIN_ENABLE] & ckLevel; // see [R9]
  end

  usm_clk_div u_pscDiv (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .divisor (pre_r[7:0]),
    .tick    (pscTick),
    .level   ()
  );

  usm_clk_div u_ckDiv (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .divisor ({3'b000, pre_r[4:0]}),
    .tick    (),
    .level   (ckLevel)
  );

  usm_ir_codec u_ir (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .infrared_mode_enable     (infrared_mode_enable),
    .lowPower (ctrl_r[`USM_C_INFRARED_LOW_POWER]),
    .bitLen   (baud_r),
    .pscTick  (pscTick),
    .bitStart (bitStart_r),
    .bitVal   (txLine_r),
    .rxPin    (rxPin),
    .txPin    (irTx),
    .rxDec    (irRx)
  );
endmodule // usm_core

`default_nettype wire

// ===== hdl/usm_consts.vh
// Constants of the serial special-modes block: offsets, fields, resets.
// Assumes inclusion by bare name from the design files.
`ifndef USM_CONSTS_VH
`define USM_CONSTS_VH

// ==========================================================
// Register byte offsets
`define USM_A_CTRL  8'h00
`define USM_A_IEN   8'h04
`define USM_A_PRE   8'h08
`define USM_A_BAUD  8'h0c
`define USM_A_TMO   8'h10
`define USM_A_STAT  8'h14
`define USM_A_DATA  8'h18

// ==========================================================
// Control fields
`define USM_C_IR    0
`define USM_C_INFRARED_LOW_POWER  1
`define USM_C_HD    2
`define USM_C_SC    3
`define USM_C_NACK  4
`define USM_C_CLOCK_PIN_ENABLE  5
`define USM_C_MSB_FIRST_SELECT  6
`define USM_C_DATA_INVERSION_SELECT  7
`define USM_C_BLK   8
`define USM_C_HSTOP 9
`define USM_C_TXEN  10
`define USM_C_RXEN  11

// ==========================================================
// Status fields; interrupt enables use the same positions
`define USM_S_PARITY_ERR  0
`define USM_S_FRAME_ERR   1
`define USM_S_OVERRUN_ERR 2
`define USM_S_RX_FULL     3
`define USM_S_TX_COMPLETE 4
`define USM_S_TX_EMPTY    5
`define USM_S_TIMEOUT     6
`define USM_S_END_BLOCK   7

// ==========================================================
// Reset values and fixed counts
`define USM_R_CTRL     12'h000
`define USM_R_STAT     8'h30
`define USM_R_BAUD     16'h0010
`define USM_IR_LP_LAST 2'h2
`define USM_BITS_SC    4'h9
`define USM_BITS_STD   4'h8
`define USM_BLK_EXTRA  9'h004

`endif

// ===== hdl/usm_clk_div.v
// Programmable divider giving a one-cycle tick and a half-duty level.
// Assumes one clock; divisor 0 or 1 ticks every cycle.
`timescale 1ns/1ps
`default_nettype none

module usm_clk_div (
  input  wire       sys_clk,
  input  wire       sys_rst,
  input  wire [7:0] divisor,
  output wire       tick,
  output reg        level
);
  reg [7:0] cnt_r;

  // ==========================================================
  // Counter
  assign tick = ({1'b0, cnt_r} + 9'h001) >= {1'b0, divisor};

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_r <= 8'h00;
      level <= 1'b0;
    end else begin
      cnt_r <= tick ? 8'h00 : cnt_r + 8'h01;
      level <= cnt_r < {1'b0, divisor[7:1]};
    end
  end
endmodule // usm_clk_div

`default_nettype wire

// ===== hdl/usm_ir_codec.v
// Infrared return-to-zero encoder and pulse decoder.
// Assumes bit starts from the transmitter and a prescaler tick.
`timescale 1ns/1ps
`default_nettype none

module usm_ir_codec (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        infrared_mode_enable,
  input  wire        lowPower,
  input  wire [15:0] bitLen,
  input  wire        pscTick,
  input  wire        bitStart,
  input  wire        bitVal,
  input  wire        rxPin,
  output reg         txPin,
  output reg         rxDec
);
  reg  [15:0] cnt_r;
  reg  [1:0]  lpCnt_r;
  reg         seen_r;
  reg         hold_r;
  reg  [15:0] holdCnt_r;
  wire [17:0] x3 = {1'b0, bitLen, 1'b0} + {2'b00, bitLen};
  wire [15:0] pw = {2'b00, x3[17:4]};

  // ==========================================================
  // Encoder
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      txPin   <= 1'b0;
      cnt_r   <= 16'h0000;
      lpCnt_r <= 2'h0;
    end else if (infrared_mode_enable && bitStart && !bitVal) begin
      txPin   <= 1'b1;                              // see [R3]
      cnt_r   <= 16'h0000;
      lpCnt_r <= 2'h0;
    end else if (txPin) begin
      if (lowPower) begin
        if (pscTick) begin
          lpCnt_r <= lpCnt_r + 2'h1;
          if (lpCnt_r == `USM_IR_LP_LAST) txPin <= 1'b0; // see [R7]
        end
      end else begin
        cnt_r <= cnt_r + 16'h0001;
        if (cnt_r + 16'h0001 >= pw) txPin <= 1'b0;  // see [R4]
      end
    end
  end

  // ==========================================================
  // Decoder
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      seen_r    <= 1'b0;
      hold_r    <= 1'b0;
      holdCnt_r <= 16'h0000;
      rxDec     <= 1'b1;
    end else begin
      if (pscTick) seen_r <= !rxPin;
      if (pscTick && seen_r && !rxPin && !hold_r) begin
        hold_r    <= 1'b1;                          // see [R5]
        holdCnt_r <= 16'h0000;
      end else if (hold_r) begin
        holdCnt_r <= holdCnt_r + 16'h0001;
        if (holdCnt_r >= {1'b0, bitLen[15:1]}) hold_r <= 1'b0;
      end
      rxDec <= !hold_r;                             // see [R24]
    end
  end
endmodule // usm_ir_codec

`default_nettype wire

// ===== sim/usm_props.sv
// Checker on the top ports of usm_core.
// Follows baud writes for the bit period; infrared pulse width checked only outside low power.
`timescale 1ns/1ps
`default_nettype none
module usm_props (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        txPinOut,
  input wire logic        txPinOe,
  input wire logic        ckPin,
  input wire logic        irqOut
);
  logic [11:0] ctl_r;
  logic [7:0]  ien_r;
  logic [15:0] baud_r;
  logic [15:0] hiCnt_r;
  wire         wr = psel && penable && pwrite;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // Mirror of control and enable writes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctl_r   <= 12'h000;
      ien_r   <= 8'h00;
      baud_r  <= 16'h0010;
      hiCnt_r <= 16'h0000;
    end else begin
      hiCnt_r <= txPinOut ? hiCnt_r + 16'h0001 : 16'h0000;
      if (wr && paddr == 8'h0c) baud_r <= pwdata[15:0];
      if (wr && paddr == 8'h00) ctl_r <= pwdata[11:0];
      if (wr && paddr == 8'h04) ien_r <= pwdata[7:0];
    end
  end
  a_ready_const: assert property (pready) else $error("pready low");
  a_slverr_map: assert property (psel && penable |->
    pslverr == (paddr > 8'h18 || paddr[1:0] != 2'h0)) else $error("pslverr wrong");
  a_rst_quiet: assert property ($past(sys_rst) |-> !irqOut && !ckPin && txPinOut)
    else $error("reset state wrong");
  a_ck_quiet: assert property ((!(ctl_r[3] && ctl_r[5])) [*2] |-> !ckPin)
    else $error("card clock without enable");
  a_ir_pulse: assert property (ctl_r[0] && $past(ctl_r[0]) && !ctl_r[1] && $fell(txPinOut) |->
    hiCnt_r == 16'((18'(baud_r) * 18'd3) >> 4)) else $error("infrared pulse width wrong");
  a_ir_drive: assert property (ctl_r[0] |-> txPinOe) else $error("infrared pin undriven");
  a_od_low: assert property ((ctl_r[2] || ctl_r[3]) && !ctl_r[0] |-> !txPinOut)
    else $error("open drain drives high");
  a_irq_gate: assert property ((ien_r == 8'h00) [*2] |-> !irqOut)
    else $error("request without enable");
  a_tx_launch: assert property (wr && paddr == 8'h18 && ctl_r == 12'h400 |->
    ##[1:4] !txPinOut) else $error("no start bit");
  c_ck: cover property (ctl_r[3] && $rose(ckPin));
  c_ir: cover property (ctl_r[0] && $rose(txPinOut));
  c_irq: cover property ($rose(irqOut));
endmodule // usm_props
`default_nettype wire

// ===== sim/usm_card_model.sv
// Smartcard model: sends framed characters on the shared line.
// Assumes a pull-up on the line and a bit period of BAUD clocks.
`timescale 1ns/1ps
`default_nettype none
module usm_card_model #(
  parameter int BAUD = 16
) (
  input wire logic  sys_clk,
  input wire logic  txPinOut,
  input wire logic  txPinOe,
  output wire logic lineLvl
);
  logic drv = 1'b1;
  // ==========
  // Wired-AND line with pull-up
  assign lineLvl = drv && !(txPinOe && !txPinOut);
  task automatic send(input logic [7:0] b, input logic bad, input logic inv);
    logic [8:0] f;
    begin
      for (int i = 0; i < 8; i++) f[i] = inv ? ~b[7 - i] : b[i];
      f[8] = inv ^ ^b ^ bad;
      @(posedge sys_clk);
      drv <= 1'b0;
      repeat (BAUD) @(posedge sys_clk);
      for (int i = 0; i < 9; i++) begin
        drv <= f[i];
        repeat (BAUD) @(posedge sys_clk);
      end
      drv <= 1'b1;
      repeat (3 * BAUD) @(posedge sys_clk);
    end
  endtask
endmodule // usm_card_model
`default_nettype wire

// ===== sim/tb_top.sv
// Testbench: APB tasks drive the block, a card model shares the line.
// Assumes the reset bit period of 16 clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        txPinOut;
  logic        txPinOe;
  logic        lineLvl;
  logic        ckPin;
  logic        irqOut;
  logic [31:0] rdat;
  logic        slv;
  logic        nk = 1'b0;
  int          n_errors = 0;
  int          check_count = 0;
  time         t0;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (txPinOe && !txPinOut) nk <= 1'b1;
  usm_core i_usm_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txPinOut(txPinOut), .txPinOe(txPinOe), .txPinIn(lineLvl),
    .rxPin(1'b1), .ckPin(ckPin), .irqOut(irqOut));
  usm_card_model i_usm_card_model (.sys_clk(sys_clk), .txPinOut(txPinOut),
    .txPinOe(txPinOe), .lineLvl(lineLvl));
  // ==========
  // Bus tasks and checks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rdat = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    begin
      check_count++;
      if (g !== e) begin
        n_errors++;
        $display("mismatch %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task automatic results;
    begin
      if (n_errors == 0 && check_count > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask
  initial begin
    #200000;
    n_errors++;
    results();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h14);
    chk(rdat, 32'h30);
    rd(8'h1c);
    chk(32'(slv), 32'h1);
    apb(1'b1, 8'h08, 32'h0001_0004);
    apb(1'b1, 8'h00, 32'h400);
    apb(1'b1, 8'h18, 32'h55);
    repeat (200) @(posedge sys_clk);
    rd(8'h14);
    chk(rdat & 32'h30, 32'h30);
    apb(1'b1, 8'h0c, 32'h87b);
    apb(1'b1, 8'h00, 32'h401);
    apb(1'b1, 8'h18, 32'h00);
    repeat (22000) @(posedge sys_clk);
    chk(32'(txPinOut), 32'h0);
    apb(1'b1, 8'h0c, 32'h10);
    apb(1'b1, 8'h00, 32'h028);
    @(posedge ckPin);
    t0 = $time;
    @(posedge ckPin);
    chk(32'(($time - t0) / 4), 32'h4);
    apb(1'b1, 8'h00, 32'h818);
    i_usm_card_model.send(8'ha5, 1'b0, 1'b0);
    rd(8'h14);
    chk(rdat & 32'h8, 32'h8);
    apb(1'b1, 8'h04, 32'h8);
    @(posedge sys_clk);
    chk(32'(irqOut), 32'h1);
    apb(1'b1, 8'h04, 32'h0);
    rd(8'h18);
    chk(rdat, 32'ha5);
    nk = 1'b0;
    i_usm_card_model.send(8'ha5, 1'b1, 1'b0);
    chk(32'(nk), 32'h1);
    rd(8'h14);
    chk(rdat & 32'h8, 32'h0);
    nk = 1'b0;
    i_usm_card_model.send(8'ha5, 1'b1, 1'b0);
    chk(32'(nk), 32'h0);
    rd(8'h14);
    chk(rdat & 32'h1, 32'h1);
    rd(8'h18);
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h00, 32'h8d8);
    i_usm_card_model.send(8'h3b, 1'b0, 1'b1);
    rd(8'h18);
    chk(rdat, 32'h3b);
    apb(1'b1, 8'h00, 32'hd08);
    apb(1'b1, 8'h10, 32'h2);
    repeat (100) @(posedge sys_clk);
    rd(8'h14);
    chk(rdat & 32'h40, 32'h40);
    apb(1'b1, 8'h18, 32'h00);
    repeat (400) @(posedge sys_clk);
    apb(1'b1, 8'h14, 32'h0);
    for (int i = 0; i < 4; i++) begin
      i_usm_card_model.send(8'h11, 1'b0, 1'b0);
      rd(8'h14);
      chk(rdat & 32'h80, (i == 3) ? 32'h80 : 32'h0);
      rd(8'h18);
    end
    results();
  end
endmodule // tb_top
bind usm_core usm_props i_usm_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .txPinOut(txPinOut), .txPinOe(txPinOe), .ckPin(ckPin), .irqOut(irqOut));
`default_nettype wire
